//--- src/pme_pkg.sv
// Purpose: Shared constants and carriers for the management register slice
// Assumes: APB slave, 32-bit data, registers at four times their index
// Notes:   16-bit registers sit in the low half of each word
package pme_pkg;

    // ***********************************
    // Register indexes and address width
    // ***********************************
    localparam logic [7:0]  IDX_MMD_ACCESS_CONTROL = 8'h0D;
    localparam logic [7:0]  IDX_MMD_WINDOW         = 8'h0E;
    localparam logic [7:0]  IDX_XCVR_CONTROL       = 8'h10;
    localparam logic [7:0]  IDX_XCVR_STATUS        = 8'h11;
    localparam logic [7:0]  IDX_SOFT_RESET         = 8'h18;
    localparam logic [7:0]  IDX_IRQ_STATUS         = 8'h19;
    localparam logic [7:0]  IDX_IRQ_MASK           = 8'h1A;
    localparam int          ADDR_W                 = 12;

    // ***********************************
    // Field positions and codes
    // ***********************************
    localparam int          AC_FUNC_LSB     = 14;
    localparam int          AC_DEVAD_LSB    = 0;
    localparam logic [1:0]  FUNC_ADDRESS    = 2'h0;
    localparam logic [1:0]  FUNC_DATA_HOLD  = 2'h1;
    localparam logic [1:0]  FUNC_DATA_INC   = 2'h2;
    localparam logic [1:0]  FUNC_DATA_INC_W = 2'h3;
    localparam logic [4:0]  DEVAD_MMD1      = 5'h01;
    localparam logic [4:0]  DEVAD_MMD3      = 5'h03;
    localparam logic [4:0]  DEVAD_MMD7      = 5'h07;
    localparam int          MMD_COUNT       = 3;
    localparam int          MMD_DEPTH       = 16;

    localparam int          CTRL_XOVER_LSB  = 5;
    localparam int          CTRL_CARRIER_SENSE_ON_TX     = 3;
    localparam int          CTRL_SQE        = 2;
    localparam int          CTRL_POLARITY_REVERSAL_ENABLE    = 1;
    localparam int          CTRL_JAB_DIS    = 0;
    localparam logic [15:0] CTRL_WMASK      = 16'h007F;
    localparam logic [15:0] CTRL_RESET      = 16'h0062;
    localparam logic [1:0]  XOVER_MDI       = 2'h0;
    localparam logic [1:0]  XOVER_MDIX      = 2'h1;
    localparam logic [1:0]  XOVER_AUTO      = 2'h3;
    localparam logic [1:0]  SPEED_10        = 2'h0;
    localparam logic [1:0]  SPEED_100       = 2'h1;

    // Interrupt status and mask layout
    localparam int          IRQ_W           = 5;
    localparam int          IRQ_PAGE        = 0;
    localparam int          IRQ_LINK        = 1;
    localparam int          IRQ_JABBER      = 2;
    localparam int          IRQ_POLARITY    = 3;
    localparam int          IRQ_DOWNGRADE   = 4;

    // ***********************************
    // Carriers
    // ***********************************
    typedef struct packed {
        logic [1:0] speed;
        logic       full_duplex;
        logic       an_enable;
        logic       an_complete;
        logic       link_up;
        logic       page_rx;
        logic       mdix_detected;
        logic       downgrade;
        logic       tx_pause;
        logic       rx_pause;
        logic       polarity_reversed;
        logic       jabber_seen;
        logic       tx_active;
        logic       rx_active;
    } pme_core_status_t;

    typedef struct packed {
        logic [1:0] crossover_mode;
        logic       carrier_sense;
        logic       heartbeat_test_enable;
        logic       rx_polarity_invert;
        logic       jabber_detect_enable;
        logic       soft_reset;
    } pme_core_ctrl_t;

endpackage

//--- src/pme_mmd_bank.sv
// Purpose: Storage and address registers of the extended MMD spaces
// Assumes: Strobes are single-cycle and come from the bus slave
// Notes:   Unknown device addresses read zero and ignore writes
`timescale 1ns/1ps
module pme_mmd_bank
    import pme_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Window access
    input  wire logic        win_wr,
    input  wire logic        win_rd,
    input  wire logic [1:0]  func,
    input  wire logic [4:0]  devad,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);

    localparam int IW = $clog2(MMD_DEPTH);

    logic [15:0] addr_reg [MMD_COUNT];
    logic [15:0] mem      [MMD_COUNT][MMD_DEPTH];
    logic [1:0]  sel;
    logic        sel_ok;
    logic [IW-1:0] word;

    always_comb begin
        sel_ok = 1'b1;
        case (devad)
            DEVAD_MMD1: sel = 2'h0;
            DEVAD_MMD3: sel = 2'h1;
            DEVAD_MMD7: sel = 2'h2;
            default: begin
                sel    = 2'h0;
                sel_ok = 1'b0;
            end
        endcase
    end

    // Only the low address bits select a word; space beyond the depth aliases
    assign word = addr_reg[sel][IW-1:0];

    always_comb begin
        if (!sel_ok) begin
            rdata = 16'h0000;
        end else if (func == FUNC_ADDRESS) begin
            rdata = addr_reg[sel];
        end else begin
            rdata = mem[sel][word];
        end
    end

    // ***********************************
    // Address registers
    // ***********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < MMD_COUNT; i++) begin
                addr_reg[i] <= 16'h0000;
            end
        end else if (sel_ok) begin
            if (win_wr && func == FUNC_ADDRESS) begin
                addr_reg[sel] <= wdata;
            end else if ((win_wr && func != FUNC_ADDRESS && func != FUNC_DATA_HOLD)
                         || (win_rd && func == FUNC_DATA_INC)) begin
                addr_reg[sel] <= addr_reg[sel] + 16'h0001;
            end
        end
    end

    // ***********************************
    // Data words
    // ***********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < MMD_COUNT; i++) begin
                for (int j = 0; j < MMD_DEPTH; j++) begin
                    mem[i][j] <= 16'h0000;
                end
            end
        end else if (sel_ok && win_wr && func != FUNC_ADDRESS) begin
            mem[sel][word] <= wdata;
        end
    end

endmodule

//--- src/pme_regs.sv
// Purpose: APB register slice of a 10/100 transceiver management block
// Assumes: Core status arrives from logic on pclk, so it is not synchronised
// Notes:   pready is always high; read data is captured in the setup cycle
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - Access-control bits 15:14 pick address access (00) or data access; write-only.
// - Data codes: 01 no increment, 10 increment on read and write, 11 on write.
// - Bits 4:0 select MMD1, MMD3 or MMD7; bits 13:5 reserved read-only.
// - Address function: window write loads the chosen MMD's address register.
// - Data function: window reaches chosen MMD word pointed by its address register.
// - Control bits 6:5 select crossover: 11 auto, 01 crossed, 00 straight; reset 11.
// - New crossover setting takes effect only after a software reset.
// - Control bit 3 asserts carrier sense on transmit too, in 10 half and 100.
// - Control bit 2 enables heartbeat test, always off in full duplex.
// - Control bit 1 enables polarity reversal; clear forces normal polarity at 10.
// - Control bit 0 set disables 10 Mb/s jabber detection.
// - Status 15:14 report speed, bit 13 reports full duplex.
// - Status bit 12 latches page received, cleared by reading the status.
// - Status bit 11 is one when negotiation is complete or disabled.
// - Status bit 6 reports crossed wiring, following the active crossover setting.
// - Status bits 3 and 2 report pause resolution, zero when speed is forced.
// - Status bit 5 reports a wire speed downgrade.
// - Status bit 1 reversed polarity, bit 0 jabber, bit 10 link up.
module pme_regs
    import pme_pkg::*;
(
    // APB
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Transceiver core
    input  wire pme_core_status_t  core_status,
    output pme_core_ctrl_t         core_ctrl,
    // Interrupt
    output logic                   irq
);

    // ***********************************
    // Bus decode
    // ***********************************
    logic              setup_phase;
    logic              access_done;
    logic              wr_done;
    logic              rd_done;
    logic [7:0]        idx;
    logic              idx_ok;
    logic [15:0]       wdata;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign wr_done     = access_done && pwrite;
    assign rd_done     = access_done && !pwrite;
    assign idx         = paddr[9:2];
    assign wdata       = pwdata[15:0];
    assign pready      = 1'b1;

    function automatic logic index_known(input logic [7:0] i);
        case (i)
            IDX_MMD_ACCESS_CONTROL,
            IDX_MMD_WINDOW,
            IDX_XCVR_CONTROL,
            IDX_XCVR_STATUS,
            IDX_SOFT_RESET,
            IDX_IRQ_STATUS,
            IDX_IRQ_MASK: index_known = 1'b1;
            default:      index_known = 1'b0;
        endcase
    endfunction

    // Upper address bits and misaligned addresses are unmapped
    assign idx_ok = index_known(idx) && paddr[1:0] == 2'h0
                    && paddr[ADDR_W-1:10] == '0;

    function automatic logic hit(input logic [7:0] want);
        hit = idx_ok && idx == want;
    endfunction

    // ***********************************
    // MMD access control
    // ***********************************
    logic [1:0]  func_reg;
    logic [4:0]  devad_reg;
    logic [15:0] win_rdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_reg  <= FUNC_ADDRESS;
            devad_reg <= 5'h00;
        end else if (wr_done && hit(IDX_MMD_ACCESS_CONTROL)) begin
            func_reg  <= wdata[AC_FUNC_LSB +: 2];
            devad_reg <= wdata[AC_DEVAD_LSB +: 5];
        end
    end

    pme_mmd_bank u_mmd (
        .pclk    (pclk),
        .presetn (presetn),
        .win_wr  (wr_done && hit(IDX_MMD_WINDOW)),
        .win_rd  (rd_done && hit(IDX_MMD_WINDOW)),
        .func    (func_reg),
        .devad   (devad_reg),
        .wdata   (wdata),
        .rdata   (win_rdata)
    );

    // ***********************************
    // Transceiver control
    // ***********************************
    logic [15:0] ctrl_reg;
    logic [1:0]  xover_active_reg;
    logic        soft_reset_reg;
    logic        do_soft_reset;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_done && hit(IDX_XCVR_CONTROL)) begin
            ctrl_reg <= wdata & CTRL_WMASK;
        end
    end

    assign do_soft_reset = wr_done && hit(IDX_SOFT_RESET) && wdata[0];

    // Active crossover only moves on a soft reset, so a half-written mode never reaches the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xover_active_reg <= XOVER_AUTO;
        end else if (do_soft_reset) begin
            xover_active_reg <= ctrl_reg[CTRL_XOVER_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= do_soft_reset;
        end
    end

    // ***********************************
    // Core controls
    // ***********************************
    logic crs_mode_ok;
    logic is_10;
    logic crs_reg;
    logic sqe_reg;
    logic pol_inv_reg;

    assign is_10       = core_status.speed == SPEED_10;
    assign crs_mode_ok = core_status.speed == SPEED_100 || (is_10 && !core_status.full_duplex);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crs_reg     <= 1'b0;
            sqe_reg     <= 1'b0;
            pol_inv_reg <= 1'b0;
        end else begin
            crs_reg     <= core_status.rx_active
                           || (ctrl_reg[CTRL_CARRIER_SENSE_ON_TX] && crs_mode_ok
                               && core_status.tx_active);
            sqe_reg     <= ctrl_reg[CTRL_SQE] && !core_status.full_duplex;
            pol_inv_reg <= core_status.polarity_reversed
                           && !(is_10 && !ctrl_reg[CTRL_POLARITY_REVERSAL_ENABLE]);
        end
    end

    always_comb begin
        core_ctrl.crossover_mode        = xover_active_reg;
        core_ctrl.carrier_sense         = crs_reg;
        core_ctrl.heartbeat_test_enable = sqe_reg;
        core_ctrl.rx_polarity_invert    = pol_inv_reg;
        core_ctrl.jabber_detect_enable  = !ctrl_reg[CTRL_JAB_DIS];
        core_ctrl.soft_reset            = soft_reset_reg;
    end

    // ***********************************
    // Transceiver status
    // ***********************************
    logic        page_reg;
    logic        resolved;
    logic        crossed;
    logic        jabber_now;
    logic [15:0] status_word;
    logic        page_clear;

    assign resolved   = core_status.an_complete || !core_status.an_enable;
    assign jabber_now = core_status.jabber_seen && !ctrl_reg[CTRL_JAB_DIS];

    always_comb begin
        case (xover_active_reg)
            XOVER_MDIX: crossed = 1'b1;
            XOVER_MDI:  crossed = 1'b0;
            default:    crossed = core_status.mdix_detected;
        endcase
    end

    // Cleared at the capture edge, so a page is either reported or kept
    assign page_clear = setup_phase && !pwrite && hit(IDX_XCVR_STATUS);

    // A page arriving in the reading cycle stays latched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_reg <= 1'b0;
        end else if (core_status.page_rx) begin
            page_reg <= 1'b1;
        end else if (page_clear) begin
            page_reg <= 1'b0;
        end
    end

    always_comb begin
        status_word        = 16'h0000;
        status_word[15:14] = core_status.speed;
        status_word[13]    = core_status.full_duplex;
        status_word[12]    = page_reg;
        status_word[11]    = resolved;
        status_word[10]    = core_status.link_up;
        status_word[6]     = crossed;
        status_word[5]     = core_status.downgrade;
        status_word[3]     = core_status.tx_pause && core_status.an_enable && resolved;
        status_word[2]     = core_status.rx_pause && core_status.an_enable && resolved;
        status_word[1]     = pol_inv_reg;
        status_word[0]     = jabber_now;
    end

    // ***********************************
    // Interrupts
    // ***********************************
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_event;
    logic             link_d_reg;
    logic             jab_d_reg;
    logic             pol_d_reg;
    logic             dg_d_reg;
    logic [IRQ_W-1:0] irq_w1c;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_d_reg <= 1'b0;
            jab_d_reg  <= 1'b0;
            pol_d_reg  <= 1'b0;
            dg_d_reg   <= 1'b0;
        end else begin
            link_d_reg <= core_status.link_up;
            jab_d_reg  <= jabber_now;
            pol_d_reg  <= pol_inv_reg;
            dg_d_reg   <= core_status.downgrade;
        end
    end

    always_comb begin
        irq_event                = '0;
        irq_event[IRQ_PAGE]      = core_status.page_rx;
        irq_event[IRQ_LINK]      = core_status.link_up != link_d_reg;
        irq_event[IRQ_JABBER]    = jabber_now && !jab_d_reg;
        irq_event[IRQ_POLARITY]  = pol_inv_reg != pol_d_reg;
        irq_event[IRQ_DOWNGRADE] = core_status.downgrade && !dg_d_reg;
    end

    assign irq_w1c = (wr_done && hit(IDX_IRQ_STATUS)) ? wdata[IRQ_W-1:0] : '0;

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_w1c) | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= '0;
        end else if (wr_done && hit(IDX_IRQ_MASK)) begin
            irq_mask_reg <= wdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ***********************************
    // Read data
    // ***********************************
    logic [15:0] rd_word;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    always_comb begin
        rd_word = 16'h0000;
        case (idx)
            // Function and device fields are write-only; reserved bits read zero
            IDX_MMD_ACCESS_CONTROL: rd_word = 16'h0000;
            IDX_MMD_WINDOW:         rd_word = win_rdata;
            IDX_XCVR_CONTROL:       rd_word = ctrl_reg;
            IDX_XCVR_STATUS:        rd_word = status_word;
            IDX_IRQ_STATUS:         rd_word[IRQ_W-1:0] = irq_status_reg;
            IDX_IRQ_MASK:           rd_word[IRQ_W-1:0] = irq_mask_reg;
            default:                rd_word = 16'h0000;
        endcase
        if (!idx_ok) begin
            rd_word = 16'h0000;
        end
    end

    // Captured in setup so prdata comes from a flop yet needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg  <= {16'h0000, pwrite ? 16'h0000 : rd_word};
            pslverr_reg <= !idx_ok;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;

endmodule

//--- tb/pme_regs_sva.sv
// Purpose: Port-level checks on the management register slice
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound into every instance of the register slice
`timescale 1ns/1ps
module pme_regs_sva
    import pme_pkg::*;
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Core and interrupt
    input wire pme_core_status_t  core_status,
    input wire pme_core_ctrl_t    core_ctrl,
    input wire logic              irq
);
    localparam logic [ADDR_W-1:0] A_CTRL = {2'h0, IDX_XCVR_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] A_STAT = {2'h0, IDX_XCVR_STATUS, 2'h0};

    logic wr_ctrl;

    assign wr_ctrl = psel && penable && pwrite && paddr == A_CTRL;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_bad_align: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_stat_ok: assert property (psel && penable && paddr == A_STAT |-> !pslverr)
        else $error("status access refused");
    a_jab_follow: assert property (wr_ctrl |=> core_ctrl.jabber_detect_enable == !$past(pwdata[0]))
        else $error("jabber enable does not follow control bit 0");
    a_sqe_fdx: assert property (core_status.full_duplex |=> !core_ctrl.heartbeat_test_enable)
        else $error("heartbeat test on in full duplex");
    a_crs_rx: assert property (core_status.rx_active |=> core_ctrl.carrier_sense)
        else $error("carrier sense missing on receive");
    a_crs_idle: assert property (!core_status.rx_active && !core_status.tx_active |=> !core_ctrl.carrier_sense)
        else $error("carrier sense without activity");
    a_xover_soft: assert property ($changed(core_ctrl.crossover_mode) |-> core_ctrl.soft_reset)
        else $error("crossover changed without software reset");
    a_soft_pulse: assert property (core_ctrl.soft_reset |=> !core_ctrl.soft_reset)
        else $error("software reset longer than one cycle");
endmodule

bind pme_regs pme_regs_sva chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_status(core_status), .core_ctrl(core_ctrl), .irq(irq)
);

//--- tb/pme_core_model.sv
// Purpose: Behavioural transceiver core facing the register slice
// Assumes: Bench sets the core levels and asks for page events
// Notes:   A page request becomes a one-cycle pulse, as the core makes it
`timescale 1ns/1ps
module pme_core_model
    import pme_pkg::*;
(
    // Clock
    input  wire logic             pclk,
    // Bench side
    input  wire pme_core_status_t levels,
    input  wire logic             page_req,
    // Register slice side
    output pme_core_status_t      core_status
);
    logic page_q;

    always_ff @(posedge pclk) begin
        page_q <= page_req;
    end

    always_comb begin
        core_status         = levels;
        core_status.page_rx = page_req && !page_q;
    end
endmodule

//--- tb/phy_mgmt_ext_regs_bench.sv
// Purpose: Self-checking bench for the management register slice
// Assumes: APB master with tasks, core levels set through the model
// Notes:   Each access leaves two idle edges so registered outputs settle
`timescale 1ns/1ps
module phy_mgmt_ext_regs_bench import pme_pkg::*;;
    logic              pclk, presetn, psel, penable, pwrite, page_req, pready, pslverr, irq, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [1:0]        misal;
    logic [4:0]        dv [3] = '{DEVAD_MMD1, DEVAD_MMD3, DEVAD_MMD7};
    pme_core_status_t  lv, core_status;
    pme_core_ctrl_t    core_ctrl;
    int                n_errors, checks;

    pme_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_status(core_status), .core_ctrl(core_ctrl), .irq(irq));
    pme_core_model core_u (.pclk(pclk), .levels(lv), .page_req(page_req),
        .core_status(core_status));

    task automatic finish_test();
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // Waits for pready; a hang counts as a mismatch
    task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        psel    <= 1'h1;
        pwrite  <= wr_en;
        paddr   <= {2'h0, idx, misal};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 64);
        if (pready !== 1'h1) begin
            n_errors++;
            finish_test();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] want);
        apb(1'h0, idx, 32'h0);
        check(rd, want);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'h1, idx, wd);
    endtask

    task automatic ac(input logic [1:0] fn, input logic [4:0] dev);
        apb(1'h1, IDX_MMD_ACCESS_CONTROL, {16'h0, fn, 9'h0, dev});
    endtask

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    // ****************************
    // Main sequence
    // ****************************
    initial begin
        presetn        = 1'h0;
        psel           = 1'h0;
        penable        = 1'h0;
        pwrite         = 1'h0;
        paddr          = '0;
        pwdata         = '0;
        page_req       = 1'h0;
        misal          = 2'h0;
        n_errors       = 0;
        checks         = 0;
        lv             = '0;
        lv.speed       = SPEED_100;
        lv.full_duplex = 1'h1;
        lv.an_enable   = 1'h1;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rdchk(IDX_XCVR_CONTROL, 32'h0062);
        rdchk(IDX_XCVR_STATUS, 32'h6000);
        wr(IDX_XCVR_STATUS, 32'hFFFF);
        rdchk(IDX_XCVR_STATUS, 32'h6000);
        wr(IDX_XCVR_CONTROL, 32'hFFFF);
        rdchk(IDX_XCVR_CONTROL, 32'h007F);
        check({31'h0, core_ctrl.jabber_detect_enable}, 32'h0);
        check({31'h0, core_ctrl.heartbeat_test_enable}, 32'h0);
        lv.full_duplex <= 1'h0;
        lv.tx_active   <= 1'h1;
        repeat (2) @(posedge pclk);
        check({31'h0, core_ctrl.heartbeat_test_enable}, 32'h1);
        check({31'h0, core_ctrl.carrier_sense}, 32'h1);
        wr(IDX_XCVR_CONTROL, 32'h0062);
        check({31'h0, core_ctrl.carrier_sense}, 32'h0);
        lv.rx_active <= 1'h1;
        repeat (2) @(posedge pclk);
        check({31'h0, core_ctrl.carrier_sense}, 32'h1);
        lv.rx_active   <= 1'h0;
        lv.an_complete <= 1'h1;
        lv.link_up     <= 1'h1;
        lv.tx_pause    <= 1'h1;
        lv.downgrade   <= 1'h1;
        rdchk(IDX_XCVR_STATUS, 32'h4C28);
        lv.an_enable <= 1'h0;
        rdchk(IDX_XCVR_STATUS, 32'h4C20);
        lv.speed             <= SPEED_10;
        lv.polarity_reversed <= 1'h1;
        lv.jabber_seen       <= 1'h1;
        repeat (2) @(posedge pclk);
        rdchk(IDX_XCVR_STATUS, 32'h0C23);
        wr(IDX_XCVR_CONTROL, 32'h0061);
        rdchk(IDX_XCVR_STATUS, 32'h0C20);
        wr(IDX_XCVR_CONTROL, 32'h0020);
        rdchk(IDX_XCVR_STATUS, 32'h0C21);
        wr(IDX_SOFT_RESET, 32'h0001);
        rdchk(IDX_XCVR_STATUS, 32'h0C61);
        check({30'h0, core_ctrl.crossover_mode}, {30'h0, XOVER_MDIX});
        wr(IDX_XCVR_CONTROL, 32'h0000);
        wr(IDX_SOFT_RESET, 32'h0001);
        rdchk(IDX_XCVR_STATUS, 32'h0C21);
        wr(IDX_IRQ_STATUS, 32'h001F);
        page_req <= 1'h1;
        @(posedge pclk);
        page_req <= 1'h0;
        rdchk(IDX_IRQ_STATUS, 32'h0001);
        check({31'h0, irq}, 32'h0);
        rdchk(IDX_XCVR_STATUS, 32'h1C21);
        rdchk(IDX_XCVR_STATUS, 32'h0C21);
        wr(IDX_IRQ_MASK, 32'h0001);
        check({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_STATUS, 32'h0001);
        check({31'h0, irq}, 32'h0);
        page_req <= 1'h1;
        rdchk(IDX_XCVR_STATUS, 32'h0C21);
        page_req <= 1'h0;
        rdchk(IDX_XCVR_STATUS, 32'h1C21);
        ac(FUNC_ADDRESS, DEVAD_MMD3);
        wr(IDX_MMD_WINDOW, 32'h0005);
        ac(FUNC_DATA_HOLD, DEVAD_MMD3);
        wr(IDX_MMD_WINDOW, 32'hA5A5);
        rdchk(IDX_MMD_WINDOW, 32'hA5A5);
        rdchk(IDX_MMD_ACCESS_CONTROL, 32'h0000);
        ac(FUNC_DATA_INC, DEVAD_MMD3);
        rdchk(IDX_MMD_WINDOW, 32'hA5A5);
        wr(IDX_MMD_WINDOW, 32'h1111);
        ac(FUNC_ADDRESS, DEVAD_MMD3);
        rdchk(IDX_MMD_WINDOW, 32'h0007);
        ac(FUNC_DATA_INC_W, DEVAD_MMD3);
        wr(IDX_MMD_WINDOW, 32'h2222);
        apb(1'h0, IDX_MMD_WINDOW, 32'h0);
        ac(FUNC_ADDRESS, DEVAD_MMD3);
        rdchk(IDX_MMD_WINDOW, 32'h0008);
        foreach (dv[i]) begin
            ac(FUNC_ADDRESS, dv[i]);
            wr(IDX_MMD_WINDOW, 32'h0009);
            ac(FUNC_DATA_HOLD, dv[i]);
            wr(IDX_MMD_WINDOW, {27'h0, dv[i]});
        end
        foreach (dv[i]) begin
            ac(FUNC_DATA_HOLD, dv[i]);
            rdchk(IDX_MMD_WINDOW, {27'h0, dv[i]});
        end
        ac(FUNC_DATA_HOLD, 5'h02);
        rdchk(IDX_MMD_WINDOW, 32'h0000);
        apb(1'h0, 8'h05, 32'h0);
        check({31'h0, err}, 32'h1);
        misal = 2'h2;
        apb(1'h0, IDX_XCVR_CONTROL, 32'h0);
        check({31'h0, err}, 32'h1);
        misal = 2'h0;
        finish_test();
    end
endmodule
